// File: core/spi_eeprom_pkg.sv
// Shared constants and types for the serial EEPROM command logic
package spi_eeprom_pkg;

    // Op-code fields (bit 3 is don't-care or address bit 8)
    localparam logic [3:0] OP_HIGH_NIBBLE = 4'h0;
    localparam logic [2:0] SET_WRITE_LATCH_CMD = 3'h6;
    localparam logic [2:0] CLEAR_WRITE_LATCH_CMD = 3'h4;
    localparam logic [2:0] STATUS_READ_CMD = 3'h5;
    localparam logic [2:0] STATUS_WRITE_CMD = 3'h1;
    localparam logic [2:0] ARRAY_READ_CMD = 3'h3;
    localparam logic [2:0] ARRAY_WRITE_CMD = 3'h2;

    // Status register bit positions
    localparam int BUSY_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int BP_LOW_BIT = 2;
    localparam int BP_HIGH_BIT = 3;

    // Reset values
    localparam logic [1:0] BLOCK_PROTECT_RESET = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Array and page geometry
    localparam int ADDR_WIDTH = 9;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_BITS = 4;

    // Programming cycle: 5 ms at 125 MHz
    localparam int WRITE_CYCLE_US = 5000;
    localparam int CLK_MHZ = 125;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;

    // Synchronised pin levels
    typedef struct packed {
        logic sel;
        logic sclk;
        logic mosi;
        logic wp;
    } pins_t;

    // Page buffer entry: byte offset within page and data
    typedef struct packed {
        logic [3:0] offset;
        logic [7:0] data;
    } page_word_t;

endpackage : spi_eeprom_pkg

// File: core/pin_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels
    input wire logic [WIDTH-1:0] reset_val, // Levels shown during reset
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;

    // Next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Registers; first stage only feeds the second
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        if (!rst_n) begin
            sync_q <= reset_val;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = rst_n ? sync_q : reset_val;
endmodule : pin_sync

// File: core/page_fifo.sv
// Word FIFO holding page data between capture and programming
`timescale 1ns/10ps
module page_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic flush, // Discard all contents
    input wire logic in_valid, // Write request
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available
    input wire logic out_ready, // Read acknowledge
    output logic [WIDTH-1:0] out_data // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointer and count update
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
endmodule : page_fifo

// File: core/spi_eeprom_core.sv
// SPI serial EEPROM command decoder, latch, status and array logic
`timescale 1ns/10ps
module spi_eeprom_core #(
    parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CYCLES,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Power-up reset, low active
    input wire logic sel_n, // Chip select pin, low active
    input wire logic serial_clock_in, // Serial clock pin
    input wire logic mosi, // Serial data in
    input wire logic write_protect_n, // Protect pin, low protects
    output logic miso_o, // Serial data out level
    output logic miso_oe_n, // Output enable, low drives
    output logic busy // Programming cycle running
);
    ///////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    spi_eeprom_pkg::pins_t pins;
    pin_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({sel_n, serial_clock_in, mosi, write_protect_n}),
        .reset_val(4'h9),
        .sync_out(pins)
    );

    typedef enum {IDLE, OPCODE, ADDR, STAT_OUT, STAT_IN, RD_OUT, WR_IN,
                  IGNORE} state_t;
    typedef enum {P_IDLE, P_WAIT, P_DRAIN} prog_t;

    localparam int CW = $clog2(WRITE_CYCLES + 1);

    state_t st_q, st_d;
    prog_t pg_q, pg_d;
    logic sel_q, sel_d, sclk_q, sclk_d;
    logic [7:0] sh_q, sh_d, op_q, op_d, out_q, out_d, stat_new_q, stat_new_d;
    logic [2:0] bit_q, bit_d;
    logic [8:0] addr_q, addr_d;
    logic latch_q, latch_d;
    logic [1:0] bp_q, bp_d, bp_new_q, bp_new_d;
    logic so_q, so_d, oe_n_q, oe_n_d, busy_q, busy_d;
    logic stat_pend_q, stat_pend_d, byte_ok_q, byte_ok_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [7:0] mem [512];
    logic rise, fall, sel_fall, sel_rise;
    logic [7:0] shifted, status_val;
    logic [8:0] rd_addr;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic fifo_flush;
    logic start_prog, start_stat, start_arr;
    spi_eeprom_pkg::page_word_t fifo_in, fifo_out;

    ///////////////////////////////////////////////////////////////////////
    // Decode helpers

    // True when an address falls in the protected block
    function automatic logic in_block(input logic [8:0] a,
                                      input logic [1:0] bp);
        unique case (bp)
            2'h0: in_block = 1'b0;
            2'h1: in_block = (a[8:7] == 2'h3);
            2'h2: in_block = a[8];
            2'h3: in_block = 1'b1;
        endcase
    endfunction : in_block

    // True when the op-code high nibble is zero and low bits match
    function automatic logic op_is(input logic [7:0] op,
                                   input logic [2:0] code);
        op_is = (op[7:4] == spi_eeprom_pkg::OP_HIGH_NIBBLE) &&
                (op[2:0] == code);
    endfunction : op_is

    ///////////////////////////////////////////////////////////////////////
    // Page buffer between capture and programming
    page_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    ///////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised pins
    always_comb begin
        sel_d = pins.sel;
        sclk_d = pins.sclk;
        rise = !pins.sel && !sclk_q && pins.sclk;
        fall = !pins.sel && sclk_q && !pins.sclk;
        sel_fall = sel_q && !pins.sel;
        sel_rise = !sel_q && pins.sel;
        shifted = {sh_q[6:0], pins.mosi};
        status_val = busy_q ? spi_eeprom_pkg::ERASED_BYTE :
                     {4'h0, bp_q, latch_q, 1'b0};
        rd_addr = addr_q;
    end

    ///////////////////////////////////////////////////////////////////////
    // Serial transaction machine
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        op_d = op_q;
        bit_d = bit_q;
        addr_d = addr_q;
        out_d = out_q;
        so_d = so_q;
        oe_n_d = oe_n_q;
        latch_d = latch_q;
        stat_new_d = stat_new_q;
        byte_ok_d = byte_ok_q;
        fifo_in_valid = 1'b0;
        fifo_in = '0;
        fifo_flush = 1'b0;
        if (rise) begin
            sh_d = shifted;
            bit_d = bit_q + 3'h1;
        end
        unique case (st_q)
            IDLE: ;
            OPCODE: if (rise && bit_q == 3'h7) begin
                op_d = shifted;
                byte_ok_d = !busy_q;
                if (busy_q && !op_is(shifted, spi_eeprom_pkg::STATUS_READ_CMD))
                    st_d = IGNORE;
                else if (op_is(shifted, spi_eeprom_pkg::STATUS_READ_CMD)) begin
                    st_d = STAT_OUT;
                    out_d = status_val;
                end else if (op_is(shifted, spi_eeprom_pkg::STATUS_WRITE_CMD))
                    st_d = STAT_IN;
                else if (op_is(shifted, spi_eeprom_pkg::ARRAY_READ_CMD) ||
                         op_is(shifted, spi_eeprom_pkg::ARRAY_WRITE_CMD)) begin
                    st_d = ADDR;
                    addr_d[8] = shifted[3];
                end else if (op_is(shifted,
                                   spi_eeprom_pkg::SET_WRITE_LATCH_CMD) ||
                             op_is(shifted,
                                   spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD))
                    st_d = IGNORE; // acted on at deselect
                else
                    st_d = IGNORE;
            end
            ADDR: if (rise && bit_q == 3'h7) begin
                addr_d[7:0] = shifted;
                byte_ok_d = 1'b0;
                if (op_q[2:0] == spi_eeprom_pkg::ARRAY_READ_CMD) begin
                    st_d = RD_OUT;
                    out_d = mem[{op_q[3], shifted}];
                end else begin
                    st_d = WR_IN;
                    fifo_flush = 1'b1;
                end
            end
            STAT_OUT: if (rise && bit_q == 3'h7) begin
                out_d = status_val;
            end
            STAT_IN: if (rise && bit_q == 3'h7) begin
                stat_new_d = shifted;
                byte_ok_d = 1'b1;
                st_d = IGNORE; // extra bits make the count wrong
            end
            RD_OUT: if (rise && bit_q == 3'h7) begin
                addr_d = addr_q + 9'h1;
                out_d = mem[addr_q + 9'h1];
            end
            WR_IN: if (rise) begin
                byte_ok_d = (bit_q == 3'h7);
                if (bit_q == 3'h7) begin
                    fifo_in_valid = fifo_in_ready;
                    fifo_in = {addr_q[3:0], shifted};
                    addr_d = {addr_q[8:4], addr_q[3:0] + 4'h1};
                end
            end
            IGNORE: if (rise) byte_ok_d = 1'b0;
        endcase
        // Output shifts on falling edge, MSB first
        if (fall && (st_q == STAT_OUT || st_q == RD_OUT)) begin
            so_d = out_q[3'h7 - bit_q];
            oe_n_d = 1'b0;
        end
        if (sel_fall) begin
            st_d = OPCODE;
            bit_d = 3'h0;
            byte_ok_d = 1'b0;
        end
        if (sel_rise || pins.sel) begin
            oe_n_d = 1'b1;
            so_d = 1'b0;
        end
        if (sel_rise) begin
            st_d = IDLE;
            if (st_q == IGNORE && byte_ok_q && !busy_q) begin
                if (op_is(op_q, spi_eeprom_pkg::SET_WRITE_LATCH_CMD))
                    latch_d = 1'b1;
                if (op_is(op_q, spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD))
                    latch_d = 1'b0;
            end
        end
        if (start_prog) begin
            latch_d = 1'b0;
        end
        if (!pins.wp) begin
            latch_d = 1'b0;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Write acceptance at deselect
    always_comb begin
        start_stat = sel_rise && byte_ok_q && st_q == IGNORE &&
                     op_is(op_q, spi_eeprom_pkg::STATUS_WRITE_CMD) &&
                     bit_q == 3'h0 && latch_q && pins.wp;
        start_arr = sel_rise && st_q == WR_IN && byte_ok_q &&
                    fifo_out_valid && latch_q && pins.wp;
        start_prog = start_stat || start_arr;
    end

    ///////////////////////////////////////////////////////////////////////
    // Programming cycle
    always_comb begin
        pg_d = pg_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        bp_d = bp_q;
        bp_new_d = bp_new_q;
        stat_pend_d = stat_pend_q;
        fifo_out_ready = 1'b0;
        unique case (pg_q)
            P_IDLE: if (start_prog) begin
                pg_d = P_WAIT;
                busy_d = 1'b1;
                cnt_d = CW'(WRITE_CYCLES);
                stat_pend_d = start_stat;
                bp_new_d = stat_new_q[spi_eeprom_pkg::BP_HIGH_BIT:
                                      spi_eeprom_pkg::BP_LOW_BIT];
            end
            P_WAIT: begin
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    pg_d = P_DRAIN;
                end
            end
            P_DRAIN: begin
                fifo_out_ready = 1'b1;
                if (!fifo_out_valid) begin
                    pg_d = P_IDLE;
                    busy_d = 1'b0;
                    stat_pend_d = 1'b0;
                    if (stat_pend_q) begin
                        bp_d = bp_new_q;
                    end
                end
            end
        endcase
    end

    ///////////////////////////////////////////////////////////////////////
    // Array storage, written page-wise at end of cycle
    always_ff @(posedge clk) begin
        if (pg_q == P_DRAIN && fifo_out_valid && !stat_pend_q &&
            !in_block({addr_q[8:4], fifo_out.offset}, bp_q)) begin
            mem[{addr_q[8:4], fifo_out.offset}] <= fifo_out.data;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= IDLE;
            pg_q <= P_IDLE;
            sel_q <= 1'b1;
            sclk_q <= 1'b0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            bit_q <= 3'h0;
            addr_q <= 9'h000;
            out_q <= 8'h00;
            so_q <= 1'b0;
            oe_n_q <= 1'b1;
            latch_q <= 1'b0;
            bp_q <= spi_eeprom_pkg::BLOCK_PROTECT_RESET;
            bp_new_q <= spi_eeprom_pkg::BLOCK_PROTECT_RESET;
            stat_new_q <= 8'h00;
            stat_pend_q <= 1'b0;
            byte_ok_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            pg_q <= pg_d;
            sel_q <= sel_d;
            sclk_q <= sclk_d;
            sh_q <= sh_d;
            op_q <= op_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            out_q <= out_d;
            so_q <= so_d;
            oe_n_q <= oe_n_d;
            latch_q <= latch_d;
            bp_q <= bp_d;
            bp_new_q <= bp_new_d;
            stat_new_q <= stat_new_d;
            stat_pend_q <= stat_pend_d;
            byte_ok_q <= byte_ok_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
        end
    end

    assign miso_o = so_q;
    assign miso_oe_n = oe_n_q;
    assign busy = busy_q;
endmodule : spi_eeprom_core

// File: testbench/spi_eeprom_props.sv
// Concurrent checks on the pins of the serial EEPROM command logic
`timescale 1ns/10ps
module spi_eeprom_props #(
    parameter int WRITE_CYCLES = 50
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic sel_n, // Chip select pin, low active
    input wire logic serial_clock_in, // Serial clock pin
    input wire logic mosi, // Serial data in
    input wire logic write_protect_n, // Protect pin, low protects
    input wire logic miso_o, // Serial data out level
    input wire logic miso_oe_n, // Output enable, low drives
    input wire logic busy // Programming cycle running
);
    logic sck_q, sck_d, rise, fall, op_ok;
    logic [3:0] bits_q, bits_d;
    logic [7:0] op_q, op_d;
    logic [2:0] age_q, age_d;
    int busy_n_q, busy_n_d;
    ////////////////////////////////////////////////////////////////////////
    // Follow the frame: op-code bits, age of last fall, busy length
    always_comb begin
        rise = serial_clock_in && !sck_q;
        fall = !serial_clock_in && sck_q;
        sck_d = serial_clock_in;
        bits_d = bits_q;
        op_d = op_q;
        if (sel_n) begin
            bits_d = 4'h0;
            op_d = 8'h00;
        end else if (rise && bits_q < 4'h8) begin
            bits_d = bits_q + 4'h1;
            op_d = {op_q[6:0], mosi};
        end
        age_d = fall ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        busy_n_d = busy ? busy_n_q + 1 : 0;
        op_ok = op_q[7:4] == 4'h0 && op_q[2:0] != 3'h0 && op_q[2:0] != 3'h7;
    end
    // Register the helper state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            bits_q <= 4'h0;
            op_q <= 8'h00;
            age_q <= 3'h7;
            busy_n_q <= 0;
        end else begin
            sck_q <= sck_d;
            bits_q <= bits_d;
            op_q <= op_d;
            age_q <= age_d;
            busy_n_q <= busy_n_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_quiet_a: assert property ($rose(rst_n) |-> miso_oe_n && !busy)
        else $error("outputs not quiet after reset");
    idle_release_a: assert property (sel_n [*6] |-> miso_oe_n)
        else $error("output driven while deselected");
    opcode_quiet_a: assert property ((!sel_n && bits_q < 4'h8) |-> miso_oe_n)
        else $error("output driven during op-code");
    bad_op_quiet_a: assert property ((!sel_n && bits_q == 4'h8 && (!op_ok
        || (busy && op_q[2:0] != 3'h5))) |-> miso_oe_n)
        else $error("output driven after refused op-code");
    out_fall_a: assert property ((!miso_oe_n && $changed(miso_o))
        |-> age_q <= 3'h6)
        else $error("output changed away from a clock fall");
    busy_ones_a: assert property ((busy && !miso_oe_n) |-> miso_o)
        else $error("status bit not one while busy");
    busy_start_a: assert property ($rose(busy) |-> sel_n)
        else $error("busy began while selected");
    busy_min_a: assert property ($fell(busy) |-> busy_n_q >= WRITE_CYCLES)
        else $error("programming cycle too short");
    busy_max_a: assert property (busy |-> busy_n_q < WRITE_CYCLES + 300)
        else $error("programming cycle too long");
    cover property ($rose(busy));
    cover property (!sel_n && bits_q == 4'h8 && !op_ok);
    cover property (busy && !miso_oe_n);
endmodule : spi_eeprom_props
bind spi_eeprom_core spi_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_i (
    .clk(clk), .rst_n(rst_n), .sel_n(sel_n),
    .serial_clock_in(serial_clock_in), .mosi(mosi),
    .write_protect_n(write_protect_n), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .busy(busy));

// File: testbench/spi_master_model.sv
// SPI master model that frames mode 0 transfers into the EEPROM pins
`timescale 1ns/10ps
module spi_master_model (
    input wire logic clk, // System clock, paces the link
    input wire logic miso_o, // Serial out level from device
    input wire logic miso_oe_n, // Device output enable, low drives
    output logic sel_n, // Chip select, low active
    output logic sclk, // Serial clock, idle low between frames
    output logic mosi // Serial data to device
);
    logic last_q; // Last level the device drove
    logic so_line; // Wire level as the master sees it
    // A released line shows the inverse of its last level, never stale data
    assign so_line = miso_oe_n ? ~last_q : miso_o;
    always_ff @(posedge clk) begin
        last_q <= miso_oe_n ? last_q : miso_o;
    end
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask : pause
    // One frame: select, shift bits, sample the wire before each rise
    task automatic frame(input logic [7:0] tx[$], input int cut,
                         output logic [7:0] rx[$], output int drove);
        int nbits;
        logic [7:0] b;
        nbits = tx.size() * 8 - cut;
        rx = {};
        drove = 0;
        b = 8'h00;
        sel_n = 1'b0;
        pause(5);
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[i / 8][7 - (i % 8)];
            pause(5);
            b = {b[6:0], so_line};
            if (!miso_oe_n) drove++;
            sclk = 1'b1;
            pause(5);
            sclk = 1'b0;
            if (i % 8 == 7) rx.push_back(b);
        end
        pause(5);
        sel_n = 1'b1;
        mosi = ~mosi;
        pause(10);
    endtask : frame
endmodule : spi_master_model

// File: testbench/spi_eeprom_command_logic_bench.sv
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/10ps
module spi_eeprom_command_logic_bench;
    localparam int CYC = 600;
    logic clk, rst_n, sel_n, sck, mosi, wp_n, miso_o, miso_oe_n, busy;
    int n_mismatch, total_checks, drove;
    logic [7:0] rx[$];
    logic [7:0] q[$];
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    spi_eeprom_core #(.WRITE_CYCLES(CYC), .FIFO_DEPTH(32)) DUT (
        .clk(clk), .rst_n(rst_n), .sel_n(sel_n), .serial_clock_in(sck),
        .mosi(mosi), .write_protect_n(wp_n), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .busy(busy));
    spi_master_model PARTNER (.clk(clk), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .sel_n(sel_n), .sclk(sck), .mosi(mosi));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : check
    function automatic logic [7:0] op(input logic [2:0] c, input logic b3);
        return {spi_eeprom_pkg::OP_HIGH_NIBBLE, b3, c};
    endfunction : op
    task automatic cmd(input logic [7:0] o);
        q = {o};
        PARTNER.frame(q, 0, rx, drove);
    endtask : cmd
    task automatic status(input logic [7:0] exp);
        q = {op(spi_eeprom_pkg::STATUS_READ_CMD, 1'b0), 8'h00, 8'h00};
        PARTNER.frame(q, 0, rx, drove);
        check(rx[1], exp, "status");
        check(rx[2], exp, "status repeat");
    endtask : status
    task automatic sw(input logic [7:0] v);
        q = {op(spi_eeprom_pkg::STATUS_WRITE_CMD, 1'b0), v};
        PARTNER.frame(q, 0, rx, drove);
    endtask : sw
    task automatic wr(input logic [8:0] a, input logic [7:0] d[$],
                      input int cut);
        q = {op(spi_eeprom_pkg::ARRAY_WRITE_CMD, a[8]), a[7:0]};
        q = {q, d};
        PARTNER.frame(q, cut, rx, drove);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e[$]);
        q = {op(spi_eeprom_pkg::ARRAY_READ_CMD, a[8]), a[7:0]};
        foreach (e[i]) q.push_back(8'h00);
        PARTNER.frame(q, 0, rx, drove);
        foreach (e[i]) check(rx[i + 2], e[i], "read");
    endtask : rd
    // Busy start as expected (2 means either), all ones meanwhile, then end
    task automatic done(input int exp);
        int k;
        k = 0;
        if (exp != 2) check({7'h00, busy}, exp[7:0], "busy start");
        if (busy) status(8'hFF);
        while (busy && k < CYC + 400) begin
            @(negedge clk);
            k++;
        end
        check({7'h00, busy}, 8'h00, "busy end");
    endtask : done
    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch;
        status(8'h00);
        check({7'h00, miso_oe_n}, 8'h01, "released");
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b1));
        status(8'h02);
        cmd(op(spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD, 1'b1));
        status(8'h00);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
    endtask : t_latch
    task automatic t_invalid;
        logic [7:0] bad[3];
        bad = '{8'h07, 8'h00, 8'h14};
        foreach (bad[i]) begin
            q = {bad[i], 8'h00};
            PARTNER.frame(q, 0, rx, drove);
            check(drove[7:0], 8'h00, "invalid drove");
        end
        status(8'h02);
    endtask : t_invalid
    task automatic t_page;
        wr(9'h11E, {8'hA1, 8'hA2, 8'hA3}, 0);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        done(1);
        status(8'h00);
        rd(9'h11E, {8'hA1, 8'hA2});
        rd(9'h110, {8'hA3});
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h1FF, {8'h5A}, 0);
        done(1);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h000, {8'hC3}, 0);
        done(1);
        rd(9'h1FF, {8'h5A, 8'hC3});
    endtask : t_page
    task automatic t_over;
        logic [7:0] d[$];
        logic [7:0] e[$];
        for (int i = 0; i < 18; i++) d.push_back(8'h40 + i[7:0]);
        for (int i = 0; i < 16; i++) e.push_back(i < 2 ? d[i + 16] : d[i]);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h020, d, 0);
        done(1);
        rd(9'h020, e);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h020, {8'h99}, 3);
        done(0);
        rd(9'h020, {8'h50});
    endtask : t_over
    task automatic t_protect;
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        sw(8'hF4);
        done(1);
        status(8'h04);
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h1FF, {8'h11}, 0);
        done(2);
        rd(9'h1FF, {8'h5A});
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        wr(9'h17F, {8'h22}, 0);
        done(1);
        rd(9'h17F, {8'h22});
        @(negedge clk) wp_n = 1'b0;
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        sw(8'h00);
        done(0);
        wr(9'h17F, {8'h33}, 0);
        done(0);
        @(negedge clk) wp_n = 1'b1;
        status(8'h04);
        rd(9'h17F, {8'h22});
        cmd(op(spi_eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b0));
        sw(8'h00);
        done(1);
        status(8'h00);
        wr(9'h17F, {8'h44}, 0);
        done(0);
        rd(9'h17F, {8'h22});
    endtask : t_protect
    ////////////////////////////////////////////////////////////////////////
    // Reset, then run every scenario in turn
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        n_mismatch = 0;
        total_checks = 0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_latch;
        t_invalid;
        t_page;
        t_over;
        t_protect;
        stop_test;
    end
    // Cut a hang short
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule : spi_eeprom_command_logic_bench
